// ---- dv/tb.sv ----
`timescale 1ns/100ps
`include "tpc_defs.svh"
// ----------------------------------------
// Self-checking bench of the timer clock and flag block.
// ----------------------------------------
module tb;
   typedef struct {
      logic [7:0] a;
      logic [7:0] wd;
      logic [7:0] rd;
      logic [1:0] br;
   } tpc_row_t;
   logic CLK, RST_N, AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY;
   logic ARVALID, ARREADY, RVALID, RREADY, GLOBAL_IRQ_EN, ACK_CMP0, ACK_OVF0;
   logic COUNT_PIN_ZERO, COUNT_PIN_ONE, IRQ_CMP0, IRQ_OVF0, TICK1;
   logic [7:0] AWADDR, ARADDR, COUNTER0_VALUE;
   logic [31:0] WDATA, RDATA;
   logic [3:0] WSTRB;
   logic [1:0] BRESP, RRESP, rs;
   logic [31:0] rv;
   int err_count, n_tests, c, i, k;
   int dv[4] = '{8, 64, 256, 1024};
   tpc_row_t rows[8] = '{
      '{`TPC_OFF_MASK, 8'hA5, 8'hA5, `TPC_RESP_OKAY},
      '{`TPC_OFF_SFIO, 8'hFF, 8'hFE, `TPC_RESP_OKAY},
      '{`TPC_OFF_CMP0, 8'h5A, 8'h5A, `TPC_RESP_OKAY},
      '{`TPC_OFF_CNT0, 8'h3C, 8'h3C, `TPC_RESP_OKAY},
      '{`TPC_OFF_FLAGS, 8'hFF, 8'h00, `TPC_RESP_OKAY},
      '{`TPC_OFF_CTRL0, 8'hF8, 8'h08, `TPC_RESP_OKAY},
      '{`TPC_OFF_STAT, 8'h77, 8'h00, `TPC_RESP_OKAY},
      '{8'h20, 8'h77, 8'h00, `TPC_RESP_SLVERR}};

   tpc_top dut (.CLK(CLK), .RST_N(RST_N), .AWADDR(AWADDR), .AWVALID(AWVALID),
      .AWREADY(AWREADY), .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY),
      .BRESP(BRESP), .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID),
      .ARREADY(ARREADY), .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
      .GLOBAL_IRQ_EN(GLOBAL_IRQ_EN), .ACK_CMP0(ACK_CMP0), .ACK_OVF0(ACK_OVF0),
      .COUNT_PIN_ZERO(COUNT_PIN_ZERO), .COUNT_PIN_ONE(COUNT_PIN_ONE), .IRQ_CMP0(IRQ_CMP0),
      .IRQ_OVF0(IRQ_OVF0), .TICK1(TICK1), .COUNTER0_VALUE(COUNTER0_VALUE));
   tpc_pin_model u_pin (.clk(CLK), .pin0(COUNT_PIN_ZERO), .pin1(COUNT_PIN_ONE));

   // Clock of 8 ns period.
   initial begin
      CLK = 1'b0;
      forever #4 CLK = ~CLK;
   end

   // Prints the counts and the verdict, then ends the run.
   task automatic stop_test();
      $display("Checks %0d, mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : stop_test

   // Compares one value and reports a mismatch.
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_tests++;
      if (g !== e) begin
         $display("ERROR %s expected %h seen %h", nm, e, g);
         err_count++;
      end
   endtask : chk

   // Ends the run when a bounded wait ran out.
   task automatic lost(input string nm);
      $display("ERROR %s expected answer seen none", nm);
      err_count++;
      stop_test();
   endtask : lost

   // One write: address and data offered together, each released when taken.
   task automatic axw(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
      logic ad, wd;
      int j;
      @(posedge CLK);
      AWADDR <= a;
      AWVALID <= 1'b1;
      WDATA <= {24'h00_0000, d};
      WSTRB <= 4'hF;
      WVALID <= 1'b1;
      BREADY <= 1'b1;
      ad = 1'b0;
      wd = 1'b0;
      for (j = 0; j < 50 && !(ad && wd); j++) begin
         @(posedge CLK);
         if (AWREADY === 1'b1 && !ad) begin
            ad = 1'b1;
            AWVALID <= 1'b0;
         end
         if (WREADY === 1'b1 && !wd) begin
            wd = 1'b1;
            WVALID <= 1'b0;
         end
      end
      for (j = 0; j < 50 && BVALID !== 1'b1; j++) @(posedge CLK);
      if (BVALID !== 1'b1) lost("write response");
      r = BRESP;
      BREADY <= 1'b0;
   endtask : axw

   // One read: address held until taken, ready held until data seen.
   task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int j;
      @(posedge CLK);
      ARADDR <= a;
      ARVALID <= 1'b1;
      RREADY <= 1'b1;
      // The address is first seen by the slave one edge after it is offered.
      @(posedge CLK);
      for (j = 0; j < 50 && ARREADY !== 1'b1; j++) @(posedge CLK);
      if (ARREADY !== 1'b1) lost("read address");
      ARVALID <= 1'b0;
      for (j = 0; j < 50 && RVALID !== 1'b1; j++) @(posedge CLK);
      if (RVALID !== 1'b1) lost("read data");
      d = RDATA;
      r = RRESP;
      RREADY <= 1'b0;
   endtask : axr

   // Counts clocks until the counter value moves, within a bound.
   task automatic wchg(output int n, input int lim);
      logic [7:0] v;
      v = COUNTER0_VALUE;
      n = 0;
      while (COUNTER0_VALUE === v && n <= lim) begin
         @(posedge CLK);
         n++;
      end
      if (n > lim) lost("counter change");
   endtask : wchg

   // Main sequence: register table first, then hand-written cases.
   initial begin
      err_count = 0;
      n_tests = 0;
      {RST_N, AWVALID, WVALID, BREADY, ARVALID, RREADY, GLOBAL_IRQ_EN} = '0;
      {ACK_CMP0, ACK_OVF0, AWADDR, ARADDR, WDATA, WSTRB} = '0;
      repeat (5) @(posedge CLK);
      RST_N <= 1'b1;
      @(posedge CLK);
      for (i = 0; i < 8; i++) begin
         axr(rows[i].a, rv, rs);
         chk("reset value", 32'h0000_0000, rv);
         axw(rows[i].a, rows[i].wd, rs);
         chk("write resp", {30'h0, rows[i].br}, {30'h0, rs});
         axr(rows[i].a, rv, rs);
         chk("read back", {24'h00_0000, rows[i].rd}, rv);
         chk("read resp", {30'h0, rows[i].br}, {30'h0, rs});
      end
      axw(`TPC_OFF_MASK, 8'h00, rs);
      axw(`TPC_OFF_CTRL0, 8'h01, rs);
      wchg(c, 20);
      @(posedge CLK);
      k = COUNTER0_VALUE;
      @(posedge CLK);
      chk("direct step", k[7:0] + 8'h01, COUNTER0_VALUE);
      axw(`TPC_OFF_CTRL0, 8'h00, rs);
      repeat (2) @(posedge CLK);
      k = COUNTER0_VALUE;
      repeat (10) @(posedge CLK);
      chk("stopped", k[7:0], COUNTER0_VALUE);
      for (i = 0; i < 4; i++) begin
         axw(`TPC_OFF_CTRL0, `TPC_CS_DIV8 + i[2:0], rs);
         wchg(c, dv[i] + 4);
         chk("first count bound", 1, c <= dv[i] + 2);
         wchg(c, dv[i] + 4);
         chk("tap period", dv[i], c);
      end
      axw(`TPC_OFF_SFIO, 8'h01, rs);
      wchg(c, 1100);
      chk("prescaler restart", 1, c >= 1020 && c <= 1028);
      axw(`TPC_OFF_CTRL1, `TPC_CS_DIV8, rs);
      k = 0;
      repeat (80) begin
         @(posedge CLK);
         k += TICK1;
      end
      chk("shared tap ticks", 10, k);
      axw(`TPC_OFF_CTRL0, 8'h00, rs);
      axw(`TPC_OFF_CTRL1, 8'h00, rs);
      GLOBAL_IRQ_EN <= 1'b1;
      axw(`TPC_OFF_MASK, 8'h03, rs);
      axw(`TPC_OFF_CNT0, 8'hFD, rs);
      axw(`TPC_OFF_CMP0, 8'hFE, rs);
      axw(`TPC_OFF_CTRL0, 8'h01, rs);
      axw(`TPC_OFF_CTRL0, 8'h00, rs);
      axr(`TPC_OFF_FLAGS, rv, rs);
      chk("flags set", 32'h0000_0003, rv);
      chk("both requests", 2'b11, {IRQ_CMP0, IRQ_OVF0});
      GLOBAL_IRQ_EN <= 1'b0;
      repeat (2) @(posedge CLK);
      chk("masked by global", 2'b00, {IRQ_CMP0, IRQ_OVF0});
      GLOBAL_IRQ_EN <= 1'b1;
      axw(`TPC_OFF_FLAGS, 8'h00, rs);
      axr(`TPC_OFF_FLAGS, rv, rs);
      chk("zero write keeps", 32'h0000_0003, rv);
      axw(`TPC_OFF_FLAGS, 8'h02, rs);
      axr(`TPC_OFF_FLAGS, rv, rs);
      chk("one write clears", 32'h0000_0001, rv);
      chk("requests after clear", 2'b01, {IRQ_CMP0, IRQ_OVF0});
      ACK_OVF0 <= 1'b1;
      @(posedge CLK);
      ACK_OVF0 <= 1'b0;
      repeat (2) @(posedge CLK);
      chk("vector clears", 1'b0, IRQ_OVF0);
      axw(`TPC_OFF_CNT0, 8'h02, rs);
      axw(`TPC_OFF_CTRL0, 8'h09, rs);
      repeat (300) @(posedge CLK);
      axr(`TPC_OFF_FLAGS, rv, rs);
      chk("no wrap flag in phase", 1'b0, rv[0]);
      repeat (300) @(posedge CLK);
      axr(`TPC_OFF_FLAGS, rv, rs);
      chk("turn flag in phase", 1'b1, rv[0]);
      axw(`TPC_OFF_CTRL0, 8'h00, rs);
      axw(`TPC_OFF_CNT0, 8'h00, rs);
      axw(`TPC_OFF_CTRL0, `TPC_CS_RISE, rs);
      fork
         u_pin.burst(0, 3, 6);
         wchg(c, 40);
      join
      chk("pin latency", 1, c >= 8 && c <= 11);
      chk("rising count", 8'h03, COUNTER0_VALUE);
      axw(`TPC_OFF_CTRL0, `TPC_CS_FALL, rs);
      u_pin.burst(0, 3, 6);
      chk("falling count", 8'h06, COUNTER0_VALUE);
      axw(`TPC_OFF_CTRL1, `TPC_CS_RISE, rs);
      k = 0;
      fork
         u_pin.burst(1, 3, 6);
         repeat (50) begin
            @(posedge CLK);
            k += TICK1;
         end
      join
      chk("pin one ticks", 3, k);
      stop_test();
   end
endmodule : tb

// ---- dv/tpc_pin_model.sv ----
`timescale 1ns/100ps
// ----------------------------------------
// External count source for both count pins.
// ----------------------------------------
module tpc_pin_model (
   input wire logic clk, // System clock that times the pin edges.
   output logic pin0, // Count pin of counter0.
   output logic pin1 // Count pin of counter1.
);
   // Pins rest low between bursts, so a source change always meets a stable pin.
   initial begin
      pin0 = 1'b0;
      pin1 = 1'b0;
   end

   // Sends n full periods on one pin, each half period lasting at least two clocks.
   task automatic burst(input int sel, input int n, input int half);
      int i;
      int h;
      h = (half < 2) ? 2 : half;
      for (i = 0; i < 2 * n; i++) begin
         repeat (h) @(posedge clk);
         if (sel == 0)
            pin0 <= ~pin0;
         else
            pin1 <= ~pin1;
      end
      repeat (h) @(posedge clk);
   endtask : burst
endmodule : tpc_pin_model

// ---- logic/tpc_defs.svh ----
`ifndef TPC_DEFS_SVH
`define TPC_DEFS_SVH
// ----------------------------------------
// Register byte offsets.
// ----------------------------------------
`define TPC_OFF_MASK 8'h00
`define TPC_OFF_FLAGS 8'h04
`define TPC_OFF_SFIO 8'h08
`define TPC_OFF_CTRL0 8'h0C
`define TPC_OFF_CTRL1 8'h10
`define TPC_OFF_CNT0 8'h14
`define TPC_OFF_CMP0 8'h18
`define TPC_OFF_STAT 8'h1C
// ----------------------------------------
// Field positions and reset values.
// ----------------------------------------
`define TPC_BIT_OVF0 0
`define TPC_BIT_CMP0 1
`define TPC_BIT_PSR 0
`define TPC_BIT_PHASE 3
`define TPC_RST_BYTE 8'h00
`define TPC_RST_PRESC 10'h000
// ----------------------------------------
// Clock source codes.
// ----------------------------------------
`define TPC_CS_STOP 3'h0
`define TPC_CS_DIRECT 3'h1
`define TPC_CS_DIV8 3'h2
`define TPC_CS_DIV64 3'h3
`define TPC_CS_DIV256 3'h4
`define TPC_CS_DIV1024 3'h5
`define TPC_CS_FALL 3'h6
`define TPC_CS_RISE 3'h7
// ----------------------------------------
// Bus answers and counter limits.
// ----------------------------------------
`define TPC_RESP_OKAY 2'h0
`define TPC_RESP_SLVERR 2'h2
`define TPC_CNT_MAX 8'hFF
`define TPC_CNT_ZERO 8'h00
`endif

// ---- logic/tpc_pkg.sv ----
package tpc_pkg;
   // Synchroniser chain of one count pin.
   typedef struct packed {
      logic s1;
      logic s2;
      logic s3;
      logic lvl;
   } tpc_sync_t;

   // Whole state of the block.
   typedef struct packed {
      logic aw_have;
      logic [7:0] aw_addr;
      logic w_have;
      logic [7:0] w_data;
      logic w_strb0;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [1:0] rresp;
      logic [7:0] rdata;
      logic [7:0] mask;
      logic [7:0] flags;
      logic [7:0] sfio;
      logic [2:0] cs0;
      logic [2:0] cs1;
      logic phase;
      logic down;
      logic [7:0] cnt0;
      logic [7:0] cmp0;
      logic [9:0] presc;
      tpc_sync_t pin0;
      tpc_sync_t pin1;
      logic irq_cmp;
      logic irq_ovf;
      logic tick1;
   } tpc_state_t;
endpackage : tpc_pkg

// ---- logic/tpc_top.sv ----
`timescale 1ns/100ps
`include "tpc_defs.svh"
// Contract
// R01: Compare interrupt requested only when global enable, its mask bit and flag set.
// R02: Overflow interrupt requested only when global enable, its mask bit and flag set.
// R03: Compare flag, bit 1, sets when counter value equals compare value.
// R04: Either flag clears on vector taken or on writing one to it.
// R05: Overflow flag, bit 0, sets on wrap; phase mode sets it at zero turn.
// R06: Source code 1 advances the counter every system clock.
// R07: Prescaled sources divide the system clock by 8, 64, 256 and 1024.
// R08: One free-running prescaler serves both counters, each with its own tap.
// R09: First prescaled count comes 1 to N+1 cycles after enabling.
// R10: Writing one to prescaler reset bit clears prescaler; bit reads zero.
// R11: Count pins are sampled every clock through synchronisers into edge detectors.
// R12: Source 7 counts rising pin edges, source 6 counts falling edges.
// R13: Pin edge to counter update takes about 2.5 to 3.5 clocks; the three-stage chain here takes 3 to 4 clocks.
// R14: Synchronisers are clocked on the rising clock edge.
// R15: Software changes pin source only while the pin is stable.
// R16: External count half periods exceed one system clock cycle; here a pin level counts only once it is seen on two consecutive samples.
// R17: Pin sources bypass the prescaler and clock the counter directly.
// R18: Source code 0 stops the counter.
// R19: Codes 2 to 5 select taps dividing by 8, 64, 256, 1024.
// R20: Pin edges count regardless of the pin's direction setting.
// R21: Writing zero to a flag bit leaves that flag unchanged.
// R22: Prescaler is a ten-bit counter, cleared synchronously by the strobe.
module tpc_top (
   input wire logic CLK, // System clock, 125 MHz.
   input wire logic RST_N, // Asynchronous reset, active low.
   input wire logic [7:0] AWADDR, // Write address.
   input wire logic AWVALID, // Write address valid.
   output logic AWREADY, // Write address ready.
   input wire logic [31:0] WDATA, // Write data.
   input wire logic [3:0] WSTRB, // Write byte strobes.
   input wire logic WVALID, // Write data valid.
   output logic WREADY, // Write data ready.
   output logic [1:0] BRESP, // Write response.
   output logic BVALID, // Write response valid.
   input wire logic BREADY, // Write response ready.
   input wire logic [7:0] ARADDR, // Read address.
   input wire logic ARVALID, // Read address valid.
   output logic ARREADY, // Read address ready.
   output logic [31:0] RDATA, // Read data.
   output logic [1:0] RRESP, // Read response.
   output logic RVALID, // Read data valid.
   input wire logic RREADY, // Read data ready.
   input wire logic GLOBAL_IRQ_EN, // Processor global interrupt enable.
   input wire logic ACK_CMP0, // Compare vector taken, pulse.
   input wire logic ACK_OVF0, // Overflow vector taken, pulse.
   input wire logic COUNT_PIN_ZERO, // External count pin of counter0.
   input wire logic COUNT_PIN_ONE, // External count pin of counter1.
   output logic IRQ_CMP0, // Compare interrupt request.
   output logic IRQ_OVF0, // Overflow interrupt request.
   output logic TICK1, // Count pulse for counter1.
   output logic [7:0] COUNTER0_VALUE // Current counter0 value.
);

   // ----------------------------------------
   // State and helper terms.
   // ----------------------------------------
   tpc_pkg::tpc_state_t st_reg;
   tpc_pkg::tpc_state_t st_next;
   logic t8;
   logic t64;
   logic t256;
   logic t1024;
   logic rise0;
   logic fall0;
   logic rise1;
   logic fall1;
   logic tick0;
   logic wr_en;
   logic wr_psr;
   logic wr_cnt;
   logic wr_flag;
   logic set_cmp;
   logic set_ovf;
   logic [7:0] clr_flags;

   // Picks the count pulse for one source code.
   function automatic logic sel_tick(input logic [2:0] cs, input logic a8,
      input logic a64, input logic a256, input logic a1024, input logic r,
      input logic f);
      logic t;
      t = 1'b0;
      case (cs)
         `TPC_CS_STOP: t = 1'b0; // R18
         `TPC_CS_DIRECT: t = 1'b1; // R06
         `TPC_CS_DIV8: t = a8; // R19
         `TPC_CS_DIV64: t = a64; // R19
         `TPC_CS_DIV256: t = a256; // R19
         `TPC_CS_DIV1024: t = a1024; // R19
         `TPC_CS_FALL: t = f; // R12 R17
         `TPC_CS_RISE: t = r; // R12 R17
         default: t = 1'b0;
      endcase
      return t;
   endfunction : sel_tick

   // Prescaler taps fire once per period of their divisor.
   assign t8 = &st_reg.presc[2:0]; // R07
   assign t64 = &st_reg.presc[5:0]; // R07
   assign t256 = &st_reg.presc[7:0]; // R07
   assign t1024 = &st_reg.presc[9:0]; // R07 R09

   // Edge detectors act once the second and third stages agree.
   assign rise0 = (st_reg.pin0.s2 == st_reg.pin0.s3) & st_reg.pin0.s3 & ~st_reg.pin0.lvl;
   assign fall0 = (st_reg.pin0.s2 == st_reg.pin0.s3) & ~st_reg.pin0.s3 & st_reg.pin0.lvl;
   assign rise1 = (st_reg.pin1.s2 == st_reg.pin1.s3) & st_reg.pin1.s3 & ~st_reg.pin1.lvl;
   assign fall1 = (st_reg.pin1.s2 == st_reg.pin1.s3) & ~st_reg.pin1.s3 & st_reg.pin1.lvl;

   // Both counters draw from the same prescaler with their own codes.
   assign tick0 = sel_tick(st_reg.cs0, t8, t64, t256, t1024, rise0, fall0); // R08

   // Write decode of the stored address and data.
   assign wr_en = st_reg.aw_have & st_reg.w_have & ~st_reg.bvalid & st_reg.w_strb0;
   assign wr_psr = wr_en & (st_reg.aw_addr == `TPC_OFF_SFIO) & st_reg.w_data[`TPC_BIT_PSR];
   assign wr_cnt = wr_en & (st_reg.aw_addr == `TPC_OFF_CNT0);
   assign wr_flag = wr_en & (st_reg.aw_addr == `TPC_OFF_FLAGS);

   // Counter events that raise the flags.
   assign set_cmp = tick0 & ~wr_cnt & (st_reg.cnt0 == st_reg.cmp0); // R03
   assign set_ovf = tick0 & ~wr_cnt & (st_reg.phase ?
      (st_reg.down & (st_reg.cnt0 == `TPC_CNT_ZERO)) : // R05
      (st_reg.cnt0 == `TPC_CNT_MAX)); // R05

   // Flags cleared by a one written or by the vector being taken.
   assign clr_flags = (wr_flag ? st_reg.w_data : `TPC_RST_BYTE) |
      {6'h00, ACK_CMP0, ACK_OVF0}; // R04 R21

   // ----------------------------------------
   // Next state.
   // ----------------------------------------
   always_comb begin
      st_next = st_reg;
      // Free-running prescaler, cleared by the strobe.
      st_next.presc = wr_psr ? `TPC_RST_PRESC : 10'(st_reg.presc + 10'h001); // R08 R10 R22
      // Three-stage pin synchronisers; the level follows agreeing stages.
      st_next.pin0.s1 = COUNT_PIN_ZERO; // R11 R20
      st_next.pin0.s2 = st_reg.pin0.s1;
      st_next.pin0.s3 = st_reg.pin0.s2;
      if (st_reg.pin0.s2 == st_reg.pin0.s3) begin
         st_next.pin0.lvl = st_reg.pin0.s3; // R11
      end
      st_next.pin1.s1 = COUNT_PIN_ONE; // R11 R20
      st_next.pin1.s2 = st_reg.pin1.s1;
      st_next.pin1.s3 = st_reg.pin1.s2;
      if (st_reg.pin1.s2 == st_reg.pin1.s3) begin
         st_next.pin1.lvl = st_reg.pin1.s3; // R11
      end
      st_next.tick1 = sel_tick(st_reg.cs1, t8, t64, t256, t1024, rise1, fall1); // R08
      // Counter0 in normal or phase-correct counting.
      if (tick0) begin
         if (!st_reg.phase) begin
            st_next.cnt0 = 8'(st_reg.cnt0 + 8'h01); // R06
         end else if (!st_reg.down) begin
            if (st_reg.cnt0 == `TPC_CNT_MAX) begin
               st_next.down = 1'b1;
               st_next.cnt0 = 8'(st_reg.cnt0 - 8'h01);
            end else begin
               st_next.cnt0 = 8'(st_reg.cnt0 + 8'h01);
            end
         end else if (st_reg.cnt0 == `TPC_CNT_ZERO) begin
            st_next.down = 1'b0; // R05
            st_next.cnt0 = 8'(st_reg.cnt0 + 8'h01);
         end else begin
            st_next.cnt0 = 8'(st_reg.cnt0 - 8'h01);
         end
      end
      // A set in the same cycle as a clear wins.
      st_next.flags[`TPC_BIT_CMP0] = set_cmp |
         (st_reg.flags[`TPC_BIT_CMP0] & ~clr_flags[`TPC_BIT_CMP0]); // R03 R04 R21
      st_next.flags[`TPC_BIT_OVF0] = set_ovf |
         (st_reg.flags[`TPC_BIT_OVF0] & ~clr_flags[`TPC_BIT_OVF0]); // R04 R05 R21
      // Write address and data are taken in either order.
      if (AWVALID && st_reg.awready) begin
         st_next.aw_have = 1'b1;
         st_next.aw_addr = AWADDR;
      end
      if (WVALID && st_reg.wready) begin
         st_next.w_have = 1'b1;
         st_next.w_data = WDATA[7:0];
         st_next.w_strb0 = WSTRB[0];
      end
      // Register writes once both halves are held.
      if (st_reg.aw_have && st_reg.w_have && !st_reg.bvalid) begin
         st_next.aw_have = 1'b0;
         st_next.w_have = 1'b0;
         st_next.bvalid = 1'b1;
         st_next.bresp = `TPC_RESP_OKAY;
         case (st_reg.aw_addr)
            `TPC_OFF_MASK: begin
               if (st_reg.w_strb0) begin
                  st_next.mask = st_reg.w_data;
               end
            end
            `TPC_OFF_FLAGS: begin
            end
            `TPC_OFF_SFIO: begin
               if (st_reg.w_strb0) begin
                  st_next.sfio = {st_reg.w_data[7:1], 1'b0}; // R10
               end
            end
            `TPC_OFF_CTRL0: begin
               if (st_reg.w_strb0) begin
                  st_next.cs0 = st_reg.w_data[2:0];
                  st_next.phase = st_reg.w_data[`TPC_BIT_PHASE];
               end
            end
            `TPC_OFF_CTRL1: begin
               if (st_reg.w_strb0) begin
                  st_next.cs1 = st_reg.w_data[2:0];
               end
            end
            `TPC_OFF_CNT0: begin
               if (st_reg.w_strb0) begin
                  st_next.cnt0 = st_reg.w_data;
               end
            end
            `TPC_OFF_CMP0: begin
               if (st_reg.w_strb0) begin
                  st_next.cmp0 = st_reg.w_data;
               end
            end
            `TPC_OFF_STAT: begin
            end
            default: st_next.bresp = `TPC_RESP_SLVERR;
         endcase
      end
      if (st_reg.bvalid && BREADY) begin
         st_next.bvalid = 1'b0;
      end
      st_next.awready = ~st_next.aw_have & ~st_next.bvalid;
      st_next.wready = ~st_next.w_have & ~st_next.bvalid;
      // Reads answer one cycle after the address is taken.
      if (ARVALID && st_reg.arready) begin
         st_next.rvalid = 1'b1;
         st_next.rresp = `TPC_RESP_OKAY;
         case (ARADDR)
            `TPC_OFF_MASK: st_next.rdata = st_reg.mask;
            `TPC_OFF_FLAGS: st_next.rdata = st_reg.flags;
            `TPC_OFF_SFIO: st_next.rdata = st_reg.sfio; // R10
            `TPC_OFF_CTRL0: st_next.rdata = {4'h0, st_reg.phase, st_reg.cs0};
            `TPC_OFF_CTRL1: st_next.rdata = {5'h00, st_reg.cs1};
            `TPC_OFF_CNT0: st_next.rdata = st_reg.cnt0;
            `TPC_OFF_CMP0: st_next.rdata = st_reg.cmp0;
            `TPC_OFF_STAT: st_next.rdata = {5'h00, st_reg.pin1.lvl,
               st_reg.pin0.lvl, st_reg.down};
            default: begin
               st_next.rdata = `TPC_RST_BYTE;
               st_next.rresp = `TPC_RESP_SLVERR;
            end
         endcase
      end else if (st_reg.rvalid && RREADY) begin
         st_next.rvalid = 1'b0;
      end
      st_next.arready = ~st_next.rvalid;
      // Requests follow the next flag and mask under the global enable.
      st_next.irq_cmp = GLOBAL_IRQ_EN & st_next.mask[`TPC_BIT_CMP0] &
         st_next.flags[`TPC_BIT_CMP0]; // R01
      st_next.irq_ovf = GLOBAL_IRQ_EN & st_next.mask[`TPC_BIT_OVF0] &
         st_next.flags[`TPC_BIT_OVF0]; // R02
   end

   // ----------------------------------------
   // State register.
   // ----------------------------------------
   always_ff @(posedge CLK or negedge RST_N) begin // R14
      if (!RST_N) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   // Outputs taken straight from the state register.
   assign AWREADY = st_reg.awready;
   assign WREADY = st_reg.wready;
   assign BVALID = st_reg.bvalid;
   assign BRESP = st_reg.bresp;
   assign ARREADY = st_reg.arready;
   assign RVALID = st_reg.rvalid;
   assign RRESP = st_reg.rresp;
   assign RDATA = {24'h0000_00, st_reg.rdata};
   assign IRQ_CMP0 = st_reg.irq_cmp;
   assign IRQ_OVF0 = st_reg.irq_ovf;
   assign TICK1 = st_reg.tick1;
   assign COUNTER0_VALUE = st_reg.cnt0;

   // ----------------------------------------
   // Checks.
   // ----------------------------------------
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_N);

   chk_cmp_irq_cause: assert property ( // R01
      IRQ_CMP0 |-> $past(GLOBAL_IRQ_EN) && st_reg.mask[1] && st_reg.flags[1])
      else $error("compare request without its cause");
   chk_ovf_irq_cause: assert property ( // R02
      IRQ_OVF0 |-> $past(GLOBAL_IRQ_EN) && st_reg.mask[0] && st_reg.flags[0])
      else $error("overflow request without its cause");
   chk_match_sets: assert property ( // R03
      set_cmp |=> st_reg.flags[1] ##1 (st_reg.flags[1] || $past(clr_flags[1])))
      else $error("compare match did not set flag");
   chk_ack_clears: assert property ( // R04
      ACK_OVF0 && !set_ovf |=> !st_reg.flags[0])
      else $error("vector taken did not clear overflow flag");
   chk_phase_bottom: assert property ( // R05
      tick0 && st_reg.phase && st_reg.down && st_reg.cnt0 == 8'h00 && !wr_cnt
      |=> st_reg.flags[0] && !st_reg.down && st_reg.cnt0 == 8'h01)
      else $error("phase turn at zero mishandled");
   chk_direct_run: assert property ( // R06
      st_reg.cs0 == 3'h1 && !st_reg.phase && !wr_cnt
      |=> st_reg.cnt0 == 8'($past(st_reg.cnt0) + 8'h01))
      else $error("direct clock did not advance counter");
   chk_ext_rise: assert property ( // R12
      $rose(st_reg.pin0.s2) && st_reg.cs0 == 3'h7 && !st_reg.phase
      ##1 (st_reg.pin0.s2 && !wr_cnt && $stable(st_reg.cs0))
      |=> st_reg.cnt0 == 8'($past(st_reg.cnt0) + 8'h01))
      else $error("rising pin edge not counted");
   chk_stopped: assert property ( // R18
      st_reg.cs0 == 3'h0 && !wr_cnt |=> $stable(st_reg.cnt0))
      else $error("stopped counter moved");
   chk_presc_reset: assert property ( // R10
      wr_psr |=> st_reg.presc == 10'h000 && !st_reg.sfio[0])
      else $error("prescaler strobe mishandled");
   chk_presc_free: assert property ( // R22
      RST_N && !wr_psr |=> st_reg.presc == 10'($past(st_reg.presc) + 10'h001))
      else $error("prescaler did not advance");
   chk_w0_keeps: assert property ( // R21
      wr_flag && !st_reg.w_data[1] && !ACK_CMP0 && st_reg.flags[1]
      |=> st_reg.flags[1])
      else $error("writing zero cleared a flag");
   chk_tap8_spacing: assert property ( // R09
      t8 ##1 (!wr_psr [*7]) |=> t8)
      else $error("divide by eight tap period wrong");
   chk_tap8_gap: assert property ( // R07
      t8 |=> !t8 [*7])
      else $error("divide by eight tap fired early");

   cov_overflow: cover property (set_ovf ##1 IRQ_OVF0);
   cov_compare: cover property (set_cmp ##1 IRQ_CMP0);
   cov_fall_count: cover property (st_reg.cs0 == 3'h6 && fall0);
   cov_phase_turn: cover property (tick0 && st_reg.phase && st_reg.down);

endmodule : tpc_top
